/* File: core/rtc_support_pkg.sv */
// Purpose: shared constants and types for the real-time-clock support logic
// Assumes: system clock of 100 MHz, slow timebases arrive as pins
// Notes: time and calendar values are binary-coded decimal bytes
package rtc_support_pkg;

  // system clock rate
  localparam int unsigned CLK_HZ = 100000000;
  // crystal rate, in edges per second
  localparam int unsigned XTAL_HZ = 32768;
  // switch-over time from rc source to crystal, in ms
  localparam int unsigned SWITCH_MS = 250;
  // crystal absence time before fallback, in us
  localparam int unsigned LOSS_US = 500;
  // crystal edges to wait before switching over (least time, rounded up)
  localparam int unsigned SWITCH_EDGES = (XTAL_HZ * SWITCH_MS + 999) / 1000;
  // system cycles of absence before fallback (rounded down)
  localparam int unsigned LOSS_CYCLES = (CLK_HZ / 1000000) * LOSS_US;

  // sub-second counter: one second of slow ticks
  localparam logic signed [16:0] SUB_FIRST = 17'sh00000;
  localparam logic signed [16:0] SUB_LAST = 17'sh07FFF;

  // bcd boundary values
  localparam logic [7:0] BCD_00 = 8'h00;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;

  // period selection codes
  localparam logic [1:0] PERIOD_SECOND = 2'h0;
  localparam logic [1:0] PERIOD_MINUTE = 2'h1;
  localparam logic [1:0] PERIOD_HOUR = 2'h2;
  localparam logic [1:0] PERIOD_DAY = 2'h3;

  // status byte field positions
  localparam int unsigned FLAG_SECOND_BIT = 2;
  localparam int unsigned FLAG_MINUTE_BIT = 3;
  localparam int unsigned FLAG_HOUR_BIT = 4;
  localparam int unsigned FLAG_DAY_BIT = 5;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // synchroniser input positions
  localparam int unsigned SYN_RC = 0;
  localparam int unsigned SYN_XTAL = 1;
  localparam int unsigned SYN_EXT = 2;
  localparam int unsigned SYN_PRESENT = 3;
  localparam int unsigned SYN_W = 4;

  // time and calendar in bcd
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } time_calendar_t;

  // compensation bytes as written by software
  typedef struct packed {
    logic [7:0] msb;
    logic [7:0] lsb;
  } comp_bytes_t;

  // timebase source selection states
  typedef enum logic [2:0] {
    SRC_RC_WAIT = 3'h1,
    SRC_XTAL = 3'h2,
    SRC_EXT = 3'h4
  } src_state_t;

endpackage

/* File: core/pin_sync.sv */
// Purpose: two-flop synchroniser for a group of pins
// Assumes: inputs are asynchronous to clk
// Notes: only the second stage leaves the module
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // asynchronous pins
  input wire logic [WIDTH-1:0] pin_in,
  // synchronised copy
  output logic [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] meta_reg; // first stage, read only by second

  // two stages in series
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_reg <= '0;
      pin_sync_out <= '0;
    end
    else
    begin
      meta_reg <= pin_in;
      pin_sync_out <= meta_reg;
    end
  end

endmodule // pin_sync

/* File: core/rtc_support.sv */
// Purpose: drift compensation, periodic and alarm interrupts, slow timebase selection
// Assumes: calendar counting lives outside; it reads second_tick and shows its bcd time here
// Notes: slow clocks and crystal presence are pins, sampled through two flops
`timescale 1ns/1ns

module rtc_support
  import rtc_support_pkg::*;
#(
  parameter int unsigned SWITCH_COUNT = SWITCH_EDGES,
  parameter int unsigned LOSS_COUNT = LOSS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // slow clock pins
  input wire logic rc_slow_osc,
  input wire logic crystal_slow_osc,
  input wire logic ext_slow_osc,
  input wire logic crystal_present,
  input wire logic ext_osc_mode,
  // timebase status
  output logic src_is_crystal,
  output logic crystal_osc_rst,
  // compensation control
  input wire logic auto_comp_en,
  input wire comp_bytes_t comp_bytes,
  // calendar interface
  input wire time_calendar_t time_calendar,
  input wire time_calendar_t alarm_time,
  output logic second_tick,
  // interrupt control
  input wire logic [1:0] period_select,
  input wire logic periodic_irq_en,
  input wire logic alarm_irq_en,
  input wire logic alarm_status_wr,
  input wire logic alarm_status_wdata,
  // interrupt outputs and status
  output logic periodic_irq_n,
  output logic alarm_irq_n,
  output logic [7:0] status_flags,
  // wake-up
  input wire logic start_on_alarm_en,
  output logic wake_request
);

  ////////////////////////////////////////////////////////////////////////
  // pin sampling

  logic [SYN_W-1:0] pins_s; // synchronised pins
  logic src_prev_reg; // selected source, one cycle late
  logic src_now; // selected source level
  logic slow_edge; // one slow-clock rising edge
  logic xtal_prev_reg; // crystal level, one cycle late
  logic xtal_edge; // crystal rising edge

  pin_sync #(
    .WIDTH(SYN_W)
  ) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .pin_in({crystal_present, ext_slow_osc, crystal_slow_osc, rc_slow_osc}),
    .pin_sync_out(pins_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // timebase source selection

  src_state_t src_reg; // current source
  src_state_t src_next; // next source
  logic [15:0] switch_cnt_reg; // crystal edges seen while waiting
  logic [15:0] loss_cnt_reg; // cycles of crystal absence
  logic switch_done; // start-up wait complete
  logic loss_done; // crystal gone too long

  assign switch_done = switch_cnt_reg == 16'(SWITCH_COUNT - 1);
  assign loss_done = loss_cnt_reg == 16'(LOSS_COUNT - 1);
  assign xtal_edge = pins_s[SYN_XTAL] & ~xtal_prev_reg;

  // next source choice
  always_comb
  begin
    src_next = src_reg;
    case (src_reg)
      SRC_RC_WAIT:
      begin
        if (ext_osc_mode)
          src_next = SRC_EXT;
        else if (xtal_edge && switch_done && pins_s[SYN_PRESENT])
          src_next = SRC_XTAL;
      end
      SRC_XTAL:
      begin
        if (ext_osc_mode)
          src_next = SRC_EXT;
        else if (loss_done && !pins_s[SYN_PRESENT])
          src_next = SRC_RC_WAIT;
      end
      SRC_EXT:
      begin
        if (!ext_osc_mode)
          src_next = SRC_RC_WAIT;
      end
      default:
        src_next = SRC_RC_WAIT;
    endcase
  end

  // source state, rc after reset
  always_ff @(posedge clk)
  begin
    if (srst)
      src_reg <= SRC_RC_WAIT;
    else
      src_reg <= src_next;
  end

  // crystal edge count while waiting; absence restarts it
  always_ff @(posedge clk)
  begin
    if (srst)
      switch_cnt_reg <= '0;
    else if (src_reg != SRC_RC_WAIT || !pins_s[SYN_PRESENT])
      switch_cnt_reg <= '0;
    else if (xtal_edge && !switch_done)
      switch_cnt_reg <= switch_cnt_reg + 16'h0001;
  end

  // absence timer on the system clock
  always_ff @(posedge clk)
  begin
    if (srst)
      loss_cnt_reg <= '0;
    else if (pins_s[SYN_PRESENT] || src_reg != SRC_XTAL)
      loss_cnt_reg <= '0;
    else if (!loss_done)
      loss_cnt_reg <= loss_cnt_reg + 16'h0001;
  end

  // oscillator reset pulse on loss
  always_ff @(posedge clk)
  begin
    if (srst)
      crystal_osc_rst <= 1'b0;
    else
      crystal_osc_rst <= src_reg == SRC_XTAL && src_next == SRC_RC_WAIT;
  end

  assign src_is_crystal = src_reg == SRC_XTAL;

  // selected slow level: rc, crystal or external direct
  always_comb
  begin
    case (src_reg)
      SRC_XTAL: src_now = pins_s[SYN_XTAL];
      SRC_EXT: src_now = pins_s[SYN_EXT];
      default: src_now = pins_s[SYN_RC];
    endcase
  end

  // edge history
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      src_prev_reg <= 1'b0;
      xtal_prev_reg <= 1'b0;
    end
    else
    begin
      src_prev_reg <= src_now;
      xtal_prev_reg <= pins_s[SYN_XTAL];
    end
  end

  assign slow_edge = src_now & ~src_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // sub-second counter and compensation

  logic signed [16:0] sub_cnt_reg; // slow ticks within the second
  logic signed [16:0] comp_value; // signed compensation
  logic hour_point; // tick that starts second one of the hour

  assign comp_value = {comp_bytes.msb[7], comp_bytes.msb, comp_bytes.lsb};
  assign second_tick = slow_edge && sub_cnt_reg == SUB_LAST;
  assign hour_point = time_calendar.second == BCD_00 && time_calendar.minute == BCD_00;

  // count, reload, and hourly correction
  always_ff @(posedge clk)
  begin
    if (srst)
      sub_cnt_reg <= SUB_FIRST;
    else if (second_tick && auto_comp_en && hour_point)
      sub_cnt_reg <= comp_value;
    else if (second_tick)
      sub_cnt_reg <= SUB_FIRST;
    else if (slow_edge)
      sub_cnt_reg <= sub_cnt_reg + 17'sh00001;
  end

  ////////////////////////////////////////////////////////////////////////
  // periodic interrupt

  logic ev_minute; // minute rolls over
  logic ev_hour; // hour rolls over
  logic ev_day; // day rolls over
  logic period_hit; // selected period reached
  logic period_fire; // enabled periodic event

  assign ev_minute = second_tick && time_calendar.second == BCD_59;
  assign ev_hour = ev_minute && time_calendar.minute == BCD_59;
  assign ev_day = ev_hour && time_calendar.hour == BCD_23;

  // period choice
  always_comb
  begin
    case (period_select)
      PERIOD_MINUTE: period_hit = ev_minute;
      PERIOD_HOUR: period_hit = ev_hour;
      PERIOD_DAY: period_hit = ev_day;
      default: period_hit = second_tick;
    endcase
  end

  assign period_fire = period_hit && periodic_irq_en;

  // one-cycle low pulse gives the falling edge
  always_ff @(posedge clk)
  begin
    if (srst)
      periodic_irq_n <= 1'b1;
    else
      periodic_irq_n <= !period_fire;
  end

  // event flags, refreshed on each new periodic interrupt
  always_ff @(posedge clk)
  begin
    if (srst)
      status_flags <= STATUS_RESET;
    else if (period_fire)
    begin
      status_flags[FLAG_SECOND_BIT] <= second_tick;
      status_flags[FLAG_MINUTE_BIT] <= ev_minute;
      status_flags[FLAG_HOUR_BIT] <= ev_hour;
      status_flags[FLAG_DAY_BIT] <= ev_day;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm interrupt and wake-up

  logic alarm_match; // all bcd fields equal
  logic match_prev_reg; // match one cycle late
  logic alarm_set; // new enabled alarm
  logic alarm_clear; // write of one to the indication

  assign alarm_match = alarm_time == time_calendar;
  assign alarm_set = alarm_match && !match_prev_reg && alarm_irq_en;
  assign alarm_clear = alarm_status_wr && alarm_status_wdata;

  // match history
  always_ff @(posedge clk)
  begin
    if (srst)
      match_prev_reg <= 1'b0;
    else
      match_prev_reg <= alarm_match;
  end

  // low level until released; a new alarm wins over the release
  always_ff @(posedge clk)
  begin
    if (srst)
      alarm_irq_n <= 1'b1;
    else if (alarm_set)
      alarm_irq_n <= 1'b0;
    else if (alarm_clear)
      alarm_irq_n <= 1'b1;
  end

  // wake request pulse, alarm only
  always_ff @(posedge clk)
  begin
    if (srst)
      wake_request <= 1'b0;
    else
      wake_request <= alarm_set && start_on_alarm_en;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_hour_tick;
    second_tick && auto_comp_en && hour_point;
  endsequence

  sequence s_waiting_ready;
    src_reg == SRC_RC_WAIT && !ext_osc_mode && xtal_edge && switch_done && pins_s[SYN_PRESENT];
  endsequence

  sequence s_lost;
    src_reg == SRC_XTAL && !ext_osc_mode && loss_done && !pins_s[SYN_PRESENT];
  endsequence

  a_comp_load:
    assert property (s_hour_tick |=> sub_cnt_reg == $past(comp_value))
      else $error("hourly compensation not loaded");

  a_plain_reload:
    assert property (second_tick && !(auto_comp_en && hour_point) |=> sub_cnt_reg == SUB_FIRST)
      else $error("second counter not reloaded to zero");

  a_period_enable:
    assert property ($fell(periodic_irq_n) |-> $past(periodic_irq_en) && $past(period_hit))
      else $error("periodic interrupt without enabled event");

  a_period_pulse:
    assert property (!periodic_irq_n && !period_fire |=> periodic_irq_n)
      else $error("periodic pulse longer than its event");

  a_flags_hold:
    assert property (!period_fire |=> $stable(status_flags))
      else $error("event flags changed without interrupt");

  a_alarm_level:
    assert property (!alarm_irq_n && !alarm_clear |=> !alarm_irq_n)
      else $error("alarm interrupt dropped without release");

  a_alarm_release:
    assert property (alarm_clear && !alarm_set |=> alarm_irq_n)
      else $error("alarm interrupt not released");

  a_alarm_gate:
    assert property ($fell(alarm_irq_n) |-> $past(alarm_irq_en) && $past(alarm_match))
      else $error("alarm interrupt without enabled match");

  a_wake_cause:
    assert property (wake_request |-> $past(alarm_set) && $past(start_on_alarm_en))
      else $error("wake-up not caused by enabled alarm");

  a_xtal_switch:
    assert property (s_waiting_ready |=> src_is_crystal)
      else $error("no switch to crystal after start-up wait");

  a_loss_fallback:
    assert property (s_lost |=> src_reg == SRC_RC_WAIT ##0 crystal_osc_rst)
      else $error("no fallback to rc after crystal loss");

endmodule // rtc_support

/* File: tb/host_model.sv */
// Purpose: far-side model, slow clock pins and host writes
// Assumes: 10 ns system clock, tasks called at a falling edge
// Notes: rc and crystal have a 40 ns period, external oscillator 80 ns
`timescale 1ns/1ns
module host_model
  import rtc_support_pkg::*;
(
  // clock and crystal control
  input wire logic clk,
  input wire logic xtal_on,
  // slow pins
  output logic rc_slow_osc,
  output logic crystal_slow_osc,
  output logic crystal_present,
  output logic ext_slow_osc,
  // host writes
  output logic alarm_status_wr,
  output logic alarm_status_wdata,
  output comp_bytes_t comp_bytes
);
  int xtal_edges; // crystal rises since detection
  ////////////////////////////////////////////////////////////
  // rc source runs free, off the clock grid
  initial
  begin
    rc_slow_osc = 1'b0;
    #3;
    forever #20 rc_slow_osc = ~rc_slow_osc;
  end
  // external oscillator runs free at half the rc rate
  initial
  begin
    ext_slow_osc = 1'b0;
    #7;
    forever #40 ext_slow_osc = ~ext_slow_osc;
  end
  // crystal toggles only while present, idle low
  initial
  begin
    crystal_slow_osc = 1'b0;
    crystal_present = 1'b0;
    xtal_edges = 0;
    forever
    begin
      @(posedge xtal_on);
      xtal_edges = 0;
      crystal_present = 1'b1;
      #2;
      while (xtal_on)
      begin
        #20 crystal_slow_osc = 1'b1;
        xtal_edges++;
        #20 crystal_slow_osc = 1'b0;
      end
      crystal_present = 1'b0;
    end
  end
  // host register image idles cleared
  initial
  begin
    alarm_status_wr = 1'b0;
    alarm_status_wdata = 1'b0;
    comp_bytes = '0;
  end
  ////////////////////////////////////////////////////////////
  // one-cycle write to the alarm indication
  task automatic write_alarm(input logic d);
    alarm_status_wr = 1'b1;
    alarm_status_wdata = d;
    @(negedge clk);
    alarm_status_wr = 1'b0;
    alarm_status_wdata = ~d;
    @(negedge clk);
  endtask
  // host rewrites compensation, no commit
  task automatic set_comp(input logic [15:0] v);
    comp_bytes = v;
  endtask
endmodule // host_model

/* File: tb/rtc_support_tb.sv */
// Purpose: self-checking bench for the rtc support block
// Assumes: rc and crystal at clk/4, external oscillator at clk/8, short switch and loss counts
// Notes: first second is a full 32768 slow edges
`timescale 1ns/1ns
module rtc_support_tb;
  import rtc_support_pkg::*;
  localparam int SW = 4; // switch-over edges
  localparam int LS = 8; // loss cycles
  // stimulus and observed signals
  logic clk, srst, xtal_on, auto_comp_en, periodic_irq_en;
  logic alarm_irq_en, start_on_alarm_en, rc, xo, xp, awr, awd;
  logic src_is_crystal, crystal_osc_rst, second_tick;
  logic periodic_irq_n, alarm_irq_n, wake_request, fire, ext, ext_mode;
  logic [1:0] period_select;
  logic [3:0] ev;
  logic [7:0] status_flags, fexp;
  logic [31:0] lfsr_reg = 32'h5E84A280;
  comp_bytes_t comp_bytes;
  time_calendar_t time_calendar, alarm_time;
  int num_errors = 0, checked = 0, n, span;
  // tick steps: h:m:s, period, enable, compensation; last step on the external oscillator
  logic [23:0] hms [5] = '{24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h235959};
  logic [1:0] sel [5] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h3};
  logic ena [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [15:0] cmp [5] = '{16'h7F00, 16'h7E00, 16'h7F80, 16'h7F00, 16'h7F00};
  ////////////////////////////////////////////////////////////
  host_model host (.clk(clk), .xtal_on(xtal_on), .rc_slow_osc(rc), .crystal_slow_osc(xo),
    .crystal_present(xp), .ext_slow_osc(ext), .alarm_status_wr(awr), .alarm_status_wdata(awd),
    .comp_bytes(comp_bytes));
  rtc_support #(.SWITCH_COUNT(SW), .LOSS_COUNT(LS)) dut (.clk(clk), .srst(srst),
    .rc_slow_osc(rc), .crystal_slow_osc(xo), .ext_slow_osc(ext), .crystal_present(xp),
    .ext_osc_mode(ext_mode), .src_is_crystal(src_is_crystal), .crystal_osc_rst(crystal_osc_rst),
    .auto_comp_en(auto_comp_en), .comp_bytes(comp_bytes), .time_calendar(time_calendar),
    .alarm_time(alarm_time), .second_tick(second_tick), .period_select(period_select),
    .periodic_irq_en(periodic_irq_en), .alarm_irq_en(alarm_irq_en), .alarm_status_wr(awr),
    .alarm_status_wdata(awd), .periodic_irq_n(periodic_irq_n), .alarm_irq_n(alarm_irq_n),
    .status_flags(status_flags), .start_on_alarm_en(start_on_alarm_en), .wake_request(wake_request));
  ////////////////////////////////////////////////////////////
  // pseudo-random step
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // compare a design value
  task automatic chk_sig(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  // compare a bench count
  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp)
    begin
      num_errors++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  // verdict and stop
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // alarm match edge, then settle one cycle
  task automatic rematch;
    alarm_time = '1;
    @(negedge clk);
    alarm_time = time_calendar;
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog
  initial
  begin
    #3000000;
    num_errors++;
    $display("ERROR %0t timeout", $time);
    end_sim();
  end
  // main sequence
  initial
  begin
    srst = 1'b1;
    xtal_on = 1'b0;
    ext_mode = 1'b0;
    auto_comp_en = 1'b1;
    period_select = 2'h0;
    periodic_irq_en = 1'b1;
    alarm_irq_en = 1'b1;
    start_on_alarm_en = 1'b1;
    lfsr_reg = lfsr_step(lfsr_reg);
    time_calendar = {lfsr_reg[23:0], 24'h000000};
    alarm_time = '1;
    fexp = STATUS_RESET;
    repeat (16) @(negedge clk);
    chk_sig(status_flags, STATUS_RESET);
    chk_sig({periodic_irq_n, alarm_irq_n, wake_request, src_is_crystal, crystal_osc_rst, second_tick}, 8'h30);
    srst = 1'b0;
    // alarm raise, wake, refused and real release
    rematch();
    chk_sig({alarm_irq_n, wake_request}, 8'h01);
    @(negedge clk);
    chk_sig({alarm_irq_n, wake_request}, 8'h00);
    host.write_alarm(1'b0);
    chk_sig(alarm_irq_n, 8'h00);
    host.write_alarm(1'b1);
    chk_sig(alarm_irq_n, 8'h01);
    alarm_irq_en = 1'b0;
    rematch();
    repeat (2) @(negedge clk);
    chk_sig({alarm_irq_n, wake_request}, 8'h02);
    alarm_irq_en = 1'b1;
    start_on_alarm_en = 1'b0;
    rematch();
    chk_sig({alarm_irq_n, wake_request}, 8'h00);
    host.write_alarm(1'b1);
    alarm_time = '1;
    // crystal start-up, loss and restart
    for (int k = 0; k < 2; k++)
    begin
      xtal_on = 1'b1;
      n = 0;
      while (src_is_crystal !== 1'b1 && n < 200)
      begin
        @(negedge clk);
        n++;
      end
      chk_cnt(int'(host.xtal_edges >= SW && host.xtal_edges <= SW + 1), 1);
      xtal_on = 1'b0;
      @(negedge xp);
      n = 0;
      while (crystal_osc_rst !== 1'b1 && n < 100)
      begin
        @(negedge clk);
        n++;
      end
      chk_cnt(int'(n >= LS && n <= LS + 5), 1);
      @(negedge clk);
      chk_sig({src_is_crystal, crystal_osc_rst}, 8'h00);
    end
    // seconds, compensation and periodic events
    for (int i = 0; i < 5; i++)
    begin
      time_calendar[23:0] = hms[i];
      period_select = sel[i];
      periodic_irq_en = ena[i];
      ext_mode = (i == 4);
      host.set_comp(cmp[i]);
      while (second_tick !== 1'b1 && n < 140000)
      begin
        @(negedge clk);
        n++;
      end
      chk_sig(second_tick, 8'h01);
      // external edges every 8 cycles, phase unknown at the switch
      span = (32768 - int'(cmp[3])) * 8;
      if (i == 4)
        chk_cnt(int'(n >= span - 16 && n <= span + 8), 1);
      else if (i > 0)
        chk_cnt(n, (32768 - int'(cmp[i - 1])) * 4);
      ev[0] = 1'b1;
      ev[1] = hms[i][7:0] == BCD_59;
      ev[2] = ev[1] && hms[i][15:8] == BCD_59;
      ev[3] = ev[2] && hms[i][23:16] == BCD_23;
      fire = ena[i] && ev[sel[i]];
      if (fire)
        fexp = {2'b00, ev, 2'b00};
      // last step: alarm match rises on the same edge as the periodic event
      if (i == 4)
        alarm_time = time_calendar;
      @(negedge clk);
      chk_sig({alarm_irq_n, periodic_irq_n, wake_request}, {5'h00, i != 4, ~fire, 1'b0});
      chk_sig(status_flags, fexp);
      @(negedge clk);
      chk_sig(periodic_irq_n, 8'h01);
      n = 2;
    end
    end_sim();
  end
endmodule // rtc_support_tb
